// ---- hw/smx_mailbox.sv ----
`default_nettype none
module smx_mailbox (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [31:0] mailboxBase,
  output logic memReq,
  output logic memWe,
  output logic [31:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic memAck,
  input wire logic [7:0] memRdata,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  input wire logic [7:0] rxData,
  input wire logic rxReady,
  output logic rxTake,
  input wire logic ioFault,
  output logic writeOpen,
  output logic readOpen
);
  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    smx_pkg::smx_state_e st;
    smx_pkg::smx_state_e retSt;
    logic memReq;
    logic memWe;
    logic [31:0] memAddr;
    logic [7:0] memWdata;
    logic [7:0] lastCode;
    logic [7:0] reply;
    logic [7:0][31:0] ptr;
    logic [2:0] ldSel;
    logic [3:0] ldIx;
    logic [3:0] ldLast;
    logic [31:0] stAddr;
    logic [7:0] stData;
    logic wrOpen;
    logic wrUpd;
    logic rdOpen;
    logic rdUpd;
    logic rdFrozen;
    logic [7:0] wrSent;
    logic [7:0] rdRecv;
    logic sentDirty;
    logic recvDirty;
    logic txValid;
    logic [7:0] txData;
    logic rxTake;
  } smx_state_s;

  smx_state_s s_q;
  smx_state_s s_d;

  logic wfPush;
  logic wfReady;
  logic wfValid;
  logic [7:0] wfData;
  logic wfPop;
  logic rfPush;
  logic rfReady;
  logic rfValid;
  logic [7:0] rfData;
  logic rfPop;
  logic [2:0] curSel;

  // ==========================================================
  // Internal buffers
  // ==========================================================
  smx_byte_fifo #(.WIDTH(smx_pkg::BUF_WIDTH), .DEPTH(smx_pkg::BUF_DEPTH)) u_wbuf (
    .clock(clock),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .inValid(wfPush),
    .inData(memRdata),
    .inReady(wfReady),
    .outValid(wfValid),
    .outData(wfData),
    .outReady(wfPop)
  );

  smx_byte_fifo #(.WIDTH(smx_pkg::BUF_WIDTH), .DEPTH(smx_pkg::BUF_DEPTH)) u_rbuf (
    .clock(clock),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .inValid(rfPush),
    .inData(rxData),
    .inReady(rfReady),
    .outValid(rfValid),
    .outData(rfData),
    .outReady(rfPop)
  );

  // ==========================================================
  // Helpers
  // ==========================================================
  // Pointer byte order: low word high byte first, then high word
  function automatic logic [7:0] laneOf(input logic [31:0] p, input logic [1:0] ix);
    logic [7:0] b;
    b = '0;
    case (ix)
      2'h0: b = p[15:8];
      2'h1: b = p[7:0];
      2'h2: b = p[31:24];
      default: b = p[23:16];
    endcase
    return b;
  endfunction

  function automatic logic [31:0] setLane(input logic [31:0] p, input logic [1:0] ix,
                                          input logic [7:0] b);
    logic [31:0] r;
    r = p;
    case (ix)
      2'h0: r[15:8] = b;
      2'h1: r[7:0] = b;
      2'h2: r[31:24] = b;
      default: r[23:16] = b;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] ptrAddr(input logic [31:0] base, input logic [2:0] sel,
                                          input logic [1:0] ix);
    logic [31:0] ofs;
    ofs = sel[2] ? smx_pkg::OFS_RPTR : smx_pkg::OFS_WPTR;
    return base + ofs + {28'h0, sel[1:0], 2'h0} + {30'h0, ix};
  endfunction

  // Advance with wrap from end back to begin
  function automatic logic [31:0] advance(input logic [31:0] p, input logic [31:0] beg,
                                          input logic [31:0] fin);
    return (p == fin) ? beg : p + 32'h1;
  endfunction

  assign curSel = s_q.ldSel + {1'b0, s_q.ldIx[3:2]};

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    s_d = s_q;
    s_d.txValid = 1'b0;
    s_d.rxTake = 1'b0;
    wfPush = 1'b0;
    wfPop = 1'b0;
    rfPush = 1'b0;
    rfPop = 1'b0;
    case (s_q.st)
      smx_pkg::ST_POLL: begin
        if (!s_q.memReq) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b0;
          s_d.memAddr = mailboxBase;
        end else if (memAck) begin
          s_d.memReq = 1'b0;
          s_d.lastCode = memRdata;
          s_d.st = smx_pkg::ST_BG;
          s_d.ldIx = '0;
          s_d.ldLast = smx_pkg::LOAD_BLOCK_LAST;
          if (memRdata != s_q.lastCode) begin
            case (memRdata)
              smx_pkg::CODE_READ_BYTE: begin
                if (ioFault) begin
                  s_d.reply = smx_pkg::ERR_FAULT;
                  s_d.st = smx_pkg::ST_REPLY;
                end else begin
                  s_d.rxTake = 1'b1;
                  s_d.stData = rxData;
                  s_d.stAddr = mailboxBase + smx_pkg::OFS_DATA;
                  s_d.retSt = smx_pkg::ST_REPLY;
                  s_d.reply = smx_pkg::REPLY_OK;
                  s_d.st = smx_pkg::ST_STB;
                end
              end
              smx_pkg::CODE_WRITE_BYTE: begin
                s_d.st = smx_pkg::ST_SBYTE;
              end
              smx_pkg::CODE_OPEN_WRITE: begin
                s_d.ldSel = smx_pkg::PTR_WBEG;
                s_d.retSt = smx_pkg::ST_OPENW;
                s_d.reply = smx_pkg::CODE_OPEN_WRITE;
                s_d.st = smx_pkg::ST_LOAD;
              end
              smx_pkg::CODE_CLOSE_WRITE: begin
                s_d.wrOpen = 1'b0;
                s_d.wrUpd = 1'b0;
                s_d.reply = smx_pkg::REPLY_OK;
                s_d.st = smx_pkg::ST_REPLY;
              end
              smx_pkg::CODE_UPDATE_WRITE: begin
                s_d.wrUpd = s_q.wrOpen;
                s_d.reply = s_q.wrOpen ? smx_pkg::CODE_UPDATE_WRITE : smx_pkg::ERR_FAULT;
                s_d.st = smx_pkg::ST_REPLY;
              end
              smx_pkg::CODE_OPEN_READ: begin
                s_d.reply = smx_pkg::CODE_OPEN_READ;
                if (s_q.rdUpd) begin
                  s_d.rdFrozen = 1'b1;
                  s_d.st = smx_pkg::ST_REPLY;
                end else begin
                  s_d.ldSel = smx_pkg::PTR_RBEG;
                  s_d.retSt = smx_pkg::ST_OPENR;
                  s_d.st = smx_pkg::ST_LOAD;
                end
              end
              smx_pkg::CODE_CLOSE_READ: begin
                s_d.rdOpen = 1'b0;
                s_d.rdUpd = 1'b0;
                s_d.rdFrozen = 1'b0;
                s_d.reply = smx_pkg::REPLY_OK;
                s_d.st = smx_pkg::ST_REPLY;
              end
              smx_pkg::CODE_UPDATE_READ: begin
                s_d.rdUpd = s_q.rdOpen;
                s_d.rdFrozen = 1'b0;
                s_d.reply = s_q.rdOpen ? smx_pkg::CODE_UPDATE_READ : smx_pkg::ERR_FAULT;
                s_d.st = smx_pkg::ST_REPLY;
              end
              smx_pkg::CODE_UPDATE_BOTH: begin
                s_d.wrUpd = s_q.wrOpen;
                s_d.rdUpd = s_q.rdOpen;
                s_d.rdFrozen = 1'b0;
                s_d.reply = (s_q.wrOpen || s_q.rdOpen) ? smx_pkg::REPLY_OK : smx_pkg::ERR_FAULT;
                s_d.st = smx_pkg::ST_REPLY;
              end
              default: begin
                s_d.st = smx_pkg::ST_BG;
              end
            endcase
          end
        end
      end
      smx_pkg::ST_SBYTE: begin
        if (!s_q.memReq) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b0;
          s_d.memAddr = mailboxBase + smx_pkg::OFS_DATA;
        end else if (memAck) begin
          s_d.memReq = 1'b0;
          s_d.st = smx_pkg::ST_REPLY;
          if (ioFault) begin
            s_d.reply = smx_pkg::ERR_FAULT;
          end else if (!txReady || s_q.txValid) begin
            s_d.reply = smx_pkg::ERR_BUSY;
          end else begin
            s_d.txValid = 1'b1;
            s_d.txData = memRdata;
            s_d.reply = smx_pkg::REPLY_OK;
          end
        end
      end
      smx_pkg::ST_LOAD: begin
        if (!s_q.memReq) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b0;
          s_d.memAddr = ptrAddr(mailboxBase, curSel, s_q.ldIx[1:0]);
        end else if (memAck) begin
          s_d.memReq = 1'b0;
          s_d.ptr[curSel] = setLane(s_q.ptr[curSel], s_q.ldIx[1:0], memRdata);
          s_d.ldIx = s_q.ldIx + 4'h1;
          if (s_q.ldIx == s_q.ldLast) begin
            s_d.st = s_q.retSt;
          end
        end
      end
      smx_pkg::ST_PSTORE: begin
        if (!s_q.memReq) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b1;
          s_d.memAddr = ptrAddr(mailboxBase, curSel, s_q.ldIx[1:0]);
          s_d.memWdata = laneOf(s_q.ptr[curSel], s_q.ldIx[1:0]);
        end else if (memAck) begin
          s_d.memReq = 1'b0;
          s_d.ldIx = s_q.ldIx + 4'h1;
          if (s_q.ldIx == s_q.ldLast) begin
            s_d.st = s_q.retSt;
          end
        end
      end
      smx_pkg::ST_STB: begin
        if (!s_q.memReq) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b1;
          s_d.memAddr = s_q.stAddr;
          s_d.memWdata = s_q.stData;
        end else if (memAck) begin
          s_d.memReq = 1'b0;
          s_d.st = s_q.retSt;
        end
      end
      smx_pkg::ST_REPLY: begin
        if (!s_q.memReq) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b1;
          s_d.memAddr = mailboxBase;
          s_d.memWdata = s_q.reply;
        end else if (memAck) begin
          s_d.memReq = 1'b0;
          s_d.lastCode = s_q.reply;
          s_d.st = smx_pkg::ST_BG;
        end
      end
      smx_pkg::ST_OPENW: begin
        s_d.wrOpen = 1'b1;
        s_d.wrUpd = 1'b0;
        s_d.wrSent = '0;
        s_d.sentDirty = 1'b0;
        s_d.stAddr = mailboxBase + smx_pkg::OFS_SENT;
        s_d.stData = '0;
        s_d.retSt = smx_pkg::ST_REPLY;
        s_d.st = smx_pkg::ST_STB;
      end
      smx_pkg::ST_OPENR: begin
        s_d.rdOpen = 1'b1;
        s_d.rdUpd = 1'b0;
        s_d.rdFrozen = 1'b0;
        s_d.rdRecv = '0;
        s_d.recvDirty = 1'b0;
        s_d.stAddr = mailboxBase + smx_pkg::OFS_RECV;
        s_d.stData = '0;
        s_d.retSt = smx_pkg::ST_REPLY;
        s_d.st = smx_pkg::ST_STB;
      end
      smx_pkg::ST_BG: begin
        s_d.ldIx = '0;
        s_d.ldLast = smx_pkg::LOAD_ONE_LAST;
        s_d.retSt = smx_pkg::ST_POLL;
        if (s_q.sentDirty && s_q.wrUpd) begin
          s_d.sentDirty = 1'b0;
          s_d.stAddr = mailboxBase + smx_pkg::OFS_SENT;
          s_d.stData = s_q.wrSent;
          s_d.st = smx_pkg::ST_STB;
        end else if (s_q.recvDirty && s_q.rdUpd) begin
          s_d.recvDirty = 1'b0;
          s_d.stAddr = mailboxBase + smx_pkg::OFS_RECV;
          s_d.stData = s_q.rdRecv;
          s_d.st = smx_pkg::ST_STB;
        end else if (s_q.wrOpen && s_q.wrUpd) begin
          s_d.ldSel = smx_pkg::PTR_WLAST;
          s_d.retSt = smx_pkg::ST_WCHK;
          s_d.st = smx_pkg::ST_LOAD;
        end else begin
          s_d.st = smx_pkg::ST_WCHK;
        end
      end
      smx_pkg::ST_WCHK: begin
        // Equal pointers mean nothing pending
        if (s_q.wrOpen && wfReady &&
            (s_q.ptr[smx_pkg::PTR_WFIRST] != s_q.ptr[smx_pkg::PTR_WLAST])) begin
          s_d.st = smx_pkg::ST_WCOPY;
        end else begin
          s_d.st = smx_pkg::ST_RCHK;
        end
      end
      smx_pkg::ST_WCOPY: begin
        if (!s_q.memReq) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b0;
          s_d.memAddr = s_q.ptr[smx_pkg::PTR_WFIRST];
        end else if (memAck) begin
          s_d.memReq = 1'b0;
          wfPush = 1'b1;
          s_d.ptr[smx_pkg::PTR_WFIRST] = advance(s_q.ptr[smx_pkg::PTR_WFIRST],
            s_q.ptr[smx_pkg::PTR_WBEG], s_q.ptr[smx_pkg::PTR_WEND]);
          s_d.ldSel = smx_pkg::PTR_WFIRST;
          s_d.ldIx = '0;
          s_d.ldLast = smx_pkg::LOAD_ONE_LAST;
          s_d.retSt = smx_pkg::ST_RCHK;
          s_d.st = smx_pkg::ST_PSTORE;
        end
      end
      smx_pkg::ST_RCHK: begin
        if (s_q.rdUpd && !s_q.rdFrozen && rfValid) begin
          s_d.st = smx_pkg::ST_RCOPY;
        end else begin
          s_d.st = smx_pkg::ST_POLL;
        end
      end
      smx_pkg::ST_RCOPY: begin
        if (!s_q.memReq) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b1;
          s_d.memAddr = s_q.ptr[smx_pkg::PTR_RLAST];
          s_d.memWdata = rfData;
        end else if (memAck) begin
          s_d.memReq = 1'b0;
          rfPop = 1'b1;
          // First pointer left alone, only last advances
          s_d.ptr[smx_pkg::PTR_RLAST] = advance(s_q.ptr[smx_pkg::PTR_RLAST],
            s_q.ptr[smx_pkg::PTR_RBEG], s_q.ptr[smx_pkg::PTR_REND]);
          s_d.ldSel = smx_pkg::PTR_RLAST;
          s_d.ldIx = '0;
          s_d.ldLast = smx_pkg::LOAD_ONE_LAST;
          s_d.retSt = smx_pkg::ST_POLL;
          s_d.st = smx_pkg::ST_PSTORE;
        end
      end
      default: begin
        s_d.st = smx_pkg::ST_POLL;
      end
    endcase
    // Transmit drain runs beside the sequencer; counting after it keeps sets winning
    if (s_q.st != smx_pkg::ST_SBYTE && !s_q.txValid && txReady && wfValid) begin
      wfPop = 1'b1;
      s_d.txValid = 1'b1;
      s_d.txData = wfData;
      s_d.wrSent = s_q.wrSent + 8'h01;
      s_d.sentDirty = 1'b1;
    end
    // Receive collection continues even while frozen; paused while polling
    // so a single-byte read take never follows a collection take directly
    if (s_q.rdOpen && rxReady && !s_q.rxTake && rfReady &&
        (s_q.st != smx_pkg::ST_POLL)) begin
      rfPush = 1'b1;
      s_d.rxTake = 1'b1;
      s_d.rdRecv = s_q.rdRecv + 8'h01;
      s_d.recvDirty = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_q <= '0;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign memReq = s_q.memReq;
  assign memWe = s_q.memWe;
  assign memAddr = s_q.memAddr;
  assign memWdata = s_q.memWdata;
  assign txValid = s_q.txValid;
  assign txData = s_q.txData;
  assign rxTake = s_q.rxTake;
  assign writeOpen = s_q.wrOpen;
  assign readOpen = s_q.rdOpen;
endmodule
`default_nettype wire

// ---- hw/smx_pkg.sv ----
`default_nettype none
package smx_pkg;
  localparam logic [7:0] CODE_READ_BYTE = 8'h85;
  localparam logic [7:0] CODE_WRITE_BYTE = 8'h86;
  localparam logic [7:0] CODE_OPEN_WRITE = 8'h87;
  localparam logic [7:0] CODE_CLOSE_WRITE = 8'h88;
  localparam logic [7:0] CODE_UPDATE_WRITE = 8'h89;
  localparam logic [7:0] CODE_OPEN_READ = 8'h8a;
  localparam logic [7:0] CODE_CLOSE_READ = 8'h8b;
  localparam logic [7:0] CODE_UPDATE_READ = 8'h8c;
  localparam logic [7:0] CODE_UPDATE_BOTH = 8'h8d;
  localparam logic [7:0] REPLY_OK = 8'h00;
  localparam logic [7:0] ERR_BUSY = 8'h08;
  localparam logic [7:0] ERR_FAULT = 8'h09;
  localparam logic [31:0] OFS_DATA = 32'h1;
  localparam logic [31:0] OFS_SENT = 32'h6;
  localparam logic [31:0] OFS_WPTR = 32'h7;
  localparam logic [31:0] OFS_RECV = 32'h17;
  localparam logic [31:0] OFS_RPTR = 32'h18;
  localparam int BUF_WIDTH = 8;
  localparam int BUF_DEPTH = 256;
  localparam logic [2:0] PTR_WBEG = 3'h0;
  localparam logic [2:0] PTR_WEND = 3'h1;
  localparam logic [2:0] PTR_WFIRST = 3'h2;
  localparam logic [2:0] PTR_WLAST = 3'h3;
  localparam logic [2:0] PTR_RBEG = 3'h4;
  localparam logic [2:0] PTR_REND = 3'h5;
  localparam logic [2:0] PTR_RFIRST = 3'h6;
  localparam logic [2:0] PTR_RLAST = 3'h7;
  localparam logic [3:0] LOAD_BLOCK_LAST = 4'hf;
  localparam logic [3:0] LOAD_ONE_LAST = 4'h3;
  typedef enum logic [3:0] {
    ST_POLL, ST_BG, ST_WCHK, ST_WCOPY, ST_RCHK, ST_RCOPY, ST_LOAD,
    ST_PSTORE, ST_STB, ST_REPLY, ST_SBYTE, ST_OPENW, ST_OPENR
  } smx_state_e;
endpackage
`default_nettype wire

// ---- hw/smx_byte_fifo.sv ----
`default_nettype none
module smx_byte_fifo #(
  parameter int WIDTH = smx_pkg::BUF_WIDTH,
  parameter int DEPTH = smx_pkg::BUF_DEPTH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } smx_fifo_s;

  smx_fifo_s s_q;
  smx_fifo_s s_d;
  logic doPush;
  logic doPop;

  assign inReady = (s_q.cnt != FULL_COUNT);
  assign outValid = (s_q.cnt != '0);
  assign outData = s_q.mem[s_q.rd];
  assign doPush = inValid && inReady;
  assign doPop = outReady && outValid;

  always_comb begin
    s_d = s_q;
    if (doPush) begin
      s_d.mem[s_q.wr] = inData;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (doPop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    if (doPush && !doPop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (doPop && !doPush) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_q <= '0;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ---- sim/smx_mailbox_props.sv ----
`default_nettype none
// ==========
// Port protocol checks
module smx_mailbox_props (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [31:0] mailboxBase,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [31:0] memAddr,
  input wire logic [7:0] memWdata,
  input wire logic memAck,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic rxTake
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_tx_gap: assert property (txValid |=> !txValid)
    else $error("tx strobe twice");
  chk_tx_ready: assert property (txValid |-> $past(txReady))
    else $error("tx strobe while not ready");
  chk_take_gap: assert property (rxTake |=> !rxTake)
    else $error("rx take twice");
  chk_req_hold: assert property (memReq && !memAck |=> memReq)
    else $error("request dropped early");
  chk_addr_hold: assert property (memReq && !memAck |=> $stable(memAddr) && $stable(memWe))
    else $error("request fields moved");
  chk_wdata_hold: assert property (memReq && memWe && !memAck |=> $stable(memWdata))
    else $error("write data moved");
  chk_req_gap: assert property (memReq && memAck |=> !memReq)
    else $error("no gap after ack");
  chk_first_poll: assert property ($rose(reset_n) |=> memReq && !memWe && memAddr == mailboxBase)
    else $error("no control poll after reset");
  cover property (txValid);
  cover property (rxTake);
  cover property (memReq && memWe && memAck);
endmodule
`default_nettype wire

// ---- sim/smx_prog.sv ----
`default_nettype none
// ==========
// Program memory and transceiver
module smx_prog (
  input wire logic clock,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [31:0] memAddr,
  input wire logic [7:0] memWdata,
  output var logic memAck,
  output var logic [7:0] memRdata,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic rxTake,
  output var logic rxReady,
  output var logic [7:0] rxData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256] = '{default: 8'h00};
  logic [7:0] rxQ [$];
  logic [7:0] txSeen [$];
  logic codeWritten = 1'b0;
  int slow = 0;
  int waitCnt = 0;
  initial begin
    memAck = 1'b0;
    memRdata = 8'h00;
    rxReady = 1'b0;
    rxData = 8'h00;
  end
  // Pointer bytes: 15:8, 7:0, 31:24, 23:16
  function automatic logic [31:0] val(input int ofs, input bit isPtr);
    return isPtr ? {mem[ofs+2], mem[ofs+3], mem[ofs], mem[ofs+1]} : {24'h0, mem[ofs]};
  endfunction
  task automatic poke(input int ofs, input logic [7:0] v);
    mem[ofs] <= v;
  endtask
  task automatic setPtr(input int ofs, input logic [31:0] v);
    {mem[ofs+2], mem[ofs+3], mem[ofs], mem[ofs+1]} <= v;
  endtask
  always @(posedge clock) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (txValid) txSeen.push_back(txData);
    // Answers alternate between prompt and slow
    if (memReq && !memAck) begin
      if (waitCnt >= 3 * slow) begin
        memAck <= 1'b1;
        waitCnt <= 0;
        slow <= 1 - slow;
        if (memWe) mem[memAddr[7:0]] <= memWdata;
        if (memWe && memAddr[7:0] == 8'h00) codeWritten <= 1'b1;
        if (!memWe) memRdata <= mem[memAddr[7:0]];
      end else begin
        waitCnt <= waitCnt + 1;
      end
    end
    if (rxTake) begin
      rxReady <= 1'b0;
      rxData <= ~rxData;
      if (rxQ.size() > 0) void'(rxQ.pop_front());
    end else begin
      rxReady <= rxQ.size() > 0;
      rxData <= (rxQ.size() > 0) ? rxQ[0] : ~rxData;
    end
  end
endmodule
`default_nettype wire

// ---- sim/smx_mailbox_tb_top.sv ----
`default_nettype none
// ==========
// Mailbox request sequences
module smx_mailbox_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic txReady = 1'b1;
  logic ioFault = 1'b0;
  logic memReq, memWe, memAck, txValid, rxTake, rxReady, writeOpen, readOpen;
  logic [31:0] memAddr;
  logic [7:0] memWdata, memRdata, txData, rxData;
  logic [7:0] wrExp [5] = '{8'ha2, 8'ha3, 8'ha0, 8'hb1, 8'hb2};
  int fails = 0;
  int checksDone = 0;
  smx_mailbox i_smx_mailbox (.clock(clock), .reset_n(reset_n), .clkEn(1'b1),
    .mailboxBase(32'h0), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .txValid(txValid),
    .txData(txData), .txReady(txReady), .rxData(rxData), .rxReady(rxReady),
    .rxTake(rxTake), .ioFault(ioFault), .writeOpen(writeOpen), .readOpen(readOpen));
  smx_prog i_smx_prog (.clock(clock), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .txValid(txValid),
    .txData(txData), .rxTake(rxTake), .rxReady(rxReady), .rxData(rxData));
  initial forever #25 clock = ~clock;
  task automatic final_report();
    if (fails == 0 && checksDone > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
    checksDone++;
    if (got !== expv) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, expv, got);
    end
  endtask
  task automatic waitVal(input int ofs, input bit isPtr, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (i_smx_prog.val(ofs, isPtr) !== v && n < 4000);
    check($sformatf("field %0d", ofs), v, i_smx_prog.val(ofs, isPtr));
    if (n >= 4000) final_report();
  endtask
  // Fields are already stored; the code goes last
  task automatic issue(input logic [7:0] code, input logic [7:0] reply);
    int n;
    @(posedge clock);
    i_smx_prog.codeWritten <= 1'b0;
    i_smx_prog.poke(0, code);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (i_smx_prog.codeWritten !== 1'b1 && n < 4000);
    check("reply", reply, i_smx_prog.val(0, 1'b0));
    if (n >= 4000) begin
      fails++;
      final_report();
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    i_smx_prog.poke(1, 8'h3c);
    issue(8'h86, 8'h00);
    check("sent byte", 8'h3c, i_smx_prog.txSeen.pop_front());
    @(posedge clock) txReady <= 1'b0;
    issue(8'h86, 8'h08);
    @(posedge clock) ioFault <= 1'b1;
    issue(8'h85, 8'h09);
    @(posedge clock) ioFault <= 1'b0;
    i_smx_prog.rxQ.push_back(8'h5a);
    issue(8'h85, 8'h00);
    check("read byte", 8'h5a, i_smx_prog.val(1, 1'b0));
    check("rx backlog", 0, i_smx_prog.rxQ.size());
    issue(8'h89, 8'h09);
    @(posedge clock) txReady <= 1'b1;
    for (int i = 0; i < 4; i++) i_smx_prog.poke(8'h40 + i, {6'h28, i[1:0]});
    i_smx_prog.setPtr(7, 32'h40);
    i_smx_prog.setPtr(11, 32'h43);
    i_smx_prog.setPtr(15, 32'h42);
    i_smx_prog.setPtr(19, 32'h41);
    issue(8'h87, 8'h87);
    check("write open", 1, writeOpen);
    waitVal(15, 1'b1, 32'h41);
    i_smx_prog.poke(8'h41, 8'hb1);
    i_smx_prog.poke(8'h42, 8'hb2);
    i_smx_prog.setPtr(19, 32'h43);
    issue(8'h89, 8'h89);
    waitVal(15, 1'b1, 32'h43);
    waitVal(6, 1'b0, 32'h5);
    foreach (wrExp[i]) check("sent byte", wrExp[i], i_smx_prog.txSeen.pop_front());
    issue(8'h88, 8'h00);
    check("write open", 0, writeOpen);
    i_smx_prog.setPtr(24, 32'h60);
    i_smx_prog.setPtr(28, 32'h62);
    i_smx_prog.setPtr(32, 32'h60);
    i_smx_prog.setPtr(36, 32'h60);
    issue(8'h8a, 8'h8a);
    for (int i = 0; i < 4; i++) i_smx_prog.rxQ.push_back({6'h30, i[1:0]});
    issue(8'h8c, 8'h8c);
    waitVal(8'h60, 1'b0, 32'hc3);
    waitVal(36, 1'b1, 32'h61);
    waitVal(23, 1'b0, 32'h4);
    check("read first", 32'h60, i_smx_prog.val(32, 1'b1));
    check("read slot", 32'hc2, i_smx_prog.val(8'h62, 1'b0));
    issue(8'h8a, 8'h8a);
    i_smx_prog.rxQ.push_back(8'hd4);
    waitVal(23, 1'b0, 32'h5);
    repeat (60) @(posedge clock);
    check("frozen last", 32'h61, i_smx_prog.val(36, 1'b1));
    issue(8'h8d, 8'h00);
    waitVal(36, 1'b1, 32'h62);
    check("read slot", 32'hd4, i_smx_prog.val(8'h61, 1'b0));
    issue(8'h8b, 8'h00);
    check("read open", 0, readOpen);
    final_report();
  end
endmodule
bind smx_mailbox smx_mailbox_props i_smx_mailbox_props (.clock(clock), .reset_n(reset_n),
  .mailboxBase(mailboxBase), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
  .memWdata(memWdata), .memAck(memAck), .txValid(txValid), .txReady(txReady),
  .rxTake(rxTake));
`default_nettype wire
